/* ctd_decoder.sv */
// tag command decoder: package, then the frame parser and response builder
// assumes a same-clock byte stream from the rf front end
// and a block memory that answers its registered address at once
package ctd_pkg;
    localparam logic [7:0] CMD_IDENT = 8'h00;
    localparam logic [7:0] CMD_READ = 8'h06;
    localparam logic [7:0] CMD_WRITE = 8'h08;
    localparam logic [7:0] RSP_IDENT = 8'h01;
    localparam logic [7:0] RSP_READ = 8'h07;
    localparam logic [7:0] RSP_WRITE = 8'h09;
    localparam logic [15:0] SC_ALL = 16'hffff;
    localparam logic [15:0] SC_ANY_CAT = 16'haaff;
    localparam logic [7:0] RQ_NONE = 8'h00;
    localparam logic [7:0] RQ_SYSCODE = 8'h01;
    localparam logic [7:0] RQ_PROTO = 8'h02;
    localparam logic [15:0] PROTO_CAPS = 16'h0083;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_ERR = 8'hff;
    localparam logic [7:0] ST2_SVC_COUNT = 8'ha1;
    localparam logic [7:0] ST2_BLK_COUNT = 8'ha2;
    localparam logic [7:0] ST2_SVC_DIFF = 8'ha3;
    localparam logic [7:0] CNT_MIN = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'h0f;
    localparam int ID_BYTES = 8;
    localparam int RTD_BYTES = 8;
    localparam int BLK_BYTES = 16;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [3:0] {
        S_CMD, S_SC, S_RC, S_TS, S_ID, S_SVCN, S_SVC, S_BLKN, S_BL0, S_BL1, S_BL2,
        S_DRAIN, S_TX
    } state_t;
    typedef enum logic [2:0] {
        P_CODE, P_ID, P_RTD, P_RQ, P_ST1, P_ST2, P_BN, P_DATA
    } phase_t;
    typedef enum logic [1:0] {RQK_NONE, RQK_SYSCODE, RQK_PROTO} rq_kind_t;
endpackage

`timescale 1ns/1ps

// What this block does
// - recognise identify 0x00, read 0x06 and write 0x08 command codes
// - answer identify only for 0xffff, 0xaaff or own system code
// - request byte 0x01 system code, 0x02 capability; others mean none
// - timeslot byte ignored; always answer in the single slot
// - identify answer: 0x01, identifier, time descriptor, optional 0 or 2 bytes
// - read service count must be 1 to 15, else error answer
// - all listed service identifiers must be equal, else error answer
// - read block count must be 1 to 15, else error answer
// - read answer: 0x07, identifier, two flags, count, 16 bytes per block
// - on any error drop block count and block data from answer
// - bad block count reports flags 0xff and 0xa2 unless a service error was already flagged
// - bad service count reports flags 0xff and 0xa1
module ctd_decoder #(
    parameter int MAX_BLOCKS = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [63:0] card_identifier,
    input wire logic [63:0] resp_time_desc,
    input wire logic [15:0] own_system_code,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic mem_rd,
    output logic [7:0] mem_block,
    output logic [3:0] mem_byte,
    input wire logic [7:0] mem_rdata
);
    function automatic logic is_rx(input ctd_pkg::state_t s);
        return s != ctd_pkg::S_TX;
    endfunction

    function automatic logic cnt_ok(input logic [7:0] n);
        return n >= ctd_pkg::CNT_MIN && n <= ctd_pkg::CNT_MAX;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    ctd_pkg::state_t state_q, state_d;
    ctd_pkg::phase_t ph_q, ph_d;
    ctd_pkg::rq_kind_t rq_q, rq_d;
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] sc_q, sc_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] left_q, left_d;
    logic id_ok_q, id_ok_d;
    logic [15:0] svc0_q, svc0_d;
    logic [7:0] err_q, err_d;
    logic [7:0] blkn_q, blkn_d;
    logic [3:0] bi_q, bi_d;
    logic [7:0] blk_q [MAX_BLOCKS];
    logic [7:0] blk_d [MAX_BLOCKS];
    logic [7:0] ti_q, ti_d;
    logic rx_ready_q;
    logic mem_rd_q, mem_rd_d;
    logic [7:0] mem_block_q, mem_block_d;
    logic [3:0] mem_byte_q, mem_byte_d;
    logic acc, respond;
    ctd_pkg::state_t nxt;
    logic f_valid, f_ready, f_last;
    logic [7:0] f_data;

    assign acc = rx_valid && rx_ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // frame parser
    always_comb begin
        nxt = state_q;
        cmd_d = cmd_q;
        sc_d = sc_q;
        rq_d = rq_q;
        cnt_d = cnt_q;
        left_d = left_q;
        id_ok_d = id_ok_q;
        svc0_d = svc0_q;
        err_d = err_q;
        blkn_d = blkn_q;
        bi_d = bi_q;
        blk_d = blk_q;
        respond = 1'b0;
        if (acc) begin
            cnt_d = cnt_q + 4'h1;
            case (state_q)
                ctd_pkg::S_CMD: begin
                    cmd_d = rx_data;
                    cnt_d = 4'h0;
                    id_ok_d = 1'b1;
                    err_d = ctd_pkg::ST_OK;
                    bi_d = 4'h0;
                    if (rx_data == ctd_pkg::CMD_IDENT) begin
                        nxt = ctd_pkg::S_SC;
                    end else if (rx_data == ctd_pkg::CMD_READ
                                 || rx_data == ctd_pkg::CMD_WRITE) begin
                        nxt = ctd_pkg::S_ID;
                    end else begin
                        nxt = ctd_pkg::S_DRAIN;
                    end
                end
                ctd_pkg::S_SC: begin
                    sc_d = {sc_q[7:0], rx_data};
                    if (cnt_q == 4'h1) begin
                        nxt = ctd_pkg::S_RC;
                    end
                end
                ctd_pkg::S_RC: begin
                    if (rx_data == ctd_pkg::RQ_SYSCODE) begin
                        rq_d = ctd_pkg::RQK_SYSCODE;
                    end else if (rx_data == ctd_pkg::RQ_PROTO) begin
                        rq_d = ctd_pkg::RQK_PROTO;
                    end else begin
                        rq_d = ctd_pkg::RQK_NONE;
                    end
                    nxt = ctd_pkg::S_TS;
                end
                ctd_pkg::S_TS: begin
                    nxt = ctd_pkg::S_DRAIN;
                end
                ctd_pkg::S_ID: begin
                    if (rx_data != card_identifier[8 * (7 - cnt_q[2:0]) +: 8]) begin
                        id_ok_d = 1'b0;
                    end
                    if (cnt_q == 4'(ctd_pkg::ID_BYTES - 1)) begin
                        nxt = ctd_pkg::S_SVCN;
                    end
                end
                ctd_pkg::S_SVCN: begin
                    left_d = {rx_data[6:0], 1'b0};
                    cnt_d = 4'h0;
                    if (!cnt_ok(rx_data)) begin
                        err_d = ctd_pkg::ST2_SVC_COUNT;
                        nxt = ctd_pkg::S_DRAIN;
                    end else begin
                        nxt = ctd_pkg::S_SVC;
                    end
                end
                ctd_pkg::S_SVC: begin
                    left_d = left_q - 8'h01;
                    if (cnt_q < 4'h2) begin
                        svc0_d = {svc0_q[7:0], rx_data};
                    end else if (rx_data != svc0_q[8 * (~cnt_q[0]) +: 8]) begin
                        err_d = ctd_pkg::ST2_SVC_DIFF;
                    end
                    if (cnt_q == 4'hf) begin
                        cnt_d = 4'h2;
                    end
                    if (left_q == 8'h01) begin
                        nxt = ctd_pkg::S_BLKN;
                    end
                end
                ctd_pkg::S_BLKN: begin
                    blkn_d = rx_data;
                    if (!cnt_ok(rx_data)) begin
                        if (err_q == ctd_pkg::ST_OK) begin
                            err_d = ctd_pkg::ST2_BLK_COUNT;
                        end
                        nxt = ctd_pkg::S_DRAIN;
                    end else begin
                        nxt = ctd_pkg::S_BL0;
                    end
                end
                ctd_pkg::S_BL0: begin
                    cnt_d = 4'h0;
                    nxt = rx_data[7] ? ctd_pkg::S_BL2 : ctd_pkg::S_BL1;
                end
                ctd_pkg::S_BL1, ctd_pkg::S_BL2: begin
                    if (state_q == ctd_pkg::S_BL1) begin
                        blk_d[bi_q] = rx_data;
                        nxt = ctd_pkg::S_BL2;
                    end else begin
                        if (cnt_q == 4'h0) begin
                            blk_d[bi_q] = rx_data;
                        end
                        bi_d = bi_q + 4'h1;
                        nxt = (bi_q == 4'(blkn_q - 8'h01)) ? ctd_pkg::S_DRAIN : ctd_pkg::S_BL0;
                    end
                    if (state_q == ctd_pkg::S_BL1) begin
                        cnt_d = 4'h1;
                    end else begin
                        cnt_d = 4'h0;
                    end
                end
                default: begin
                    nxt = ctd_pkg::S_DRAIN;
                end
            endcase
            if (cmd_d == ctd_pkg::CMD_IDENT) begin
                respond = sc_d == ctd_pkg::SC_ALL || sc_d == ctd_pkg::SC_ANY_CAT
                          || sc_d == own_system_code;
            end else if (cmd_d == ctd_pkg::CMD_READ || cmd_d == ctd_pkg::CMD_WRITE) begin
                respond = id_ok_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // response builder
    always_comb begin
        state_d = nxt;
        ph_d = ph_q;
        ti_d = ti_q;
        f_valid = 1'b0;
        f_data = 8'h00;
        f_last = 1'b0;
        if (acc && rx_last) begin
            state_d = (nxt == ctd_pkg::S_DRAIN && respond) ? ctd_pkg::S_TX : ctd_pkg::S_CMD;
            ph_d = ctd_pkg::P_CODE;
            ti_d = 8'h00;
        end
        if (state_q == ctd_pkg::S_TX) begin
            f_valid = 1'b1;
            case (ph_q)
                ctd_pkg::P_CODE: begin
                    f_data = (cmd_q == ctd_pkg::CMD_IDENT) ? ctd_pkg::RSP_IDENT :
                             (cmd_q == ctd_pkg::CMD_READ) ? ctd_pkg::RSP_READ :
                             ctd_pkg::RSP_WRITE;
                end
                ctd_pkg::P_ID: begin
                    f_data = card_identifier[8 * (7 - ti_q[2:0]) +: 8];
                end
                ctd_pkg::P_RTD: begin
                    f_data = resp_time_desc[8 * (7 - ti_q[2:0]) +: 8];
                    f_last = ti_q == 8'(ctd_pkg::RTD_BYTES - 1) && rq_q == ctd_pkg::RQK_NONE;
                end
                ctd_pkg::P_RQ: begin
                    if (rq_q == ctd_pkg::RQK_SYSCODE) begin
                        f_data = ti_q[0] ? own_system_code[7:0] : own_system_code[15:8];
                    end else begin
                        f_data = ti_q[0] ? ctd_pkg::PROTO_CAPS[7:0] : ctd_pkg::PROTO_CAPS[15:8];
                    end
                    f_last = ti_q[0];
                end
                ctd_pkg::P_ST1: begin
                    f_data = (err_q == ctd_pkg::ST_OK) ? ctd_pkg::ST_OK : ctd_pkg::ST_ERR;
                end
                ctd_pkg::P_ST2: begin
                    f_data = err_q;
                    f_last = err_q != ctd_pkg::ST_OK || cmd_q == ctd_pkg::CMD_WRITE;
                end
                ctd_pkg::P_BN: begin
                    f_data = blkn_q;
                end
                default: begin
                    f_data = mem_rdata;
                    f_last = ti_q == 8'((blkn_q * ctd_pkg::BLK_BYTES) - 1);
                end
            endcase
            if (f_ready) begin
                ti_d = ti_q + 8'h01;
                case (ph_q)
                    ctd_pkg::P_CODE: begin
                        ph_d = ctd_pkg::P_ID;
                        ti_d = 8'h00;
                    end
                    ctd_pkg::P_ID: begin
                        if (ti_q == 8'(ctd_pkg::ID_BYTES - 1)) begin
                            ph_d = (cmd_q == ctd_pkg::CMD_IDENT) ? ctd_pkg::P_RTD : ctd_pkg::P_ST1;
                            ti_d = 8'h00;
                        end
                    end
                    ctd_pkg::P_RTD: begin
                        if (ti_q == 8'(ctd_pkg::RTD_BYTES - 1)) begin
                            ph_d = ctd_pkg::P_RQ;
                            ti_d = 8'h00;
                        end
                    end
                    ctd_pkg::P_ST1: begin
                        ph_d = ctd_pkg::P_ST2;
                    end
                    ctd_pkg::P_ST2: begin
                        ph_d = ctd_pkg::P_BN;
                    end
                    ctd_pkg::P_BN: begin
                        ph_d = ctd_pkg::P_DATA;
                        ti_d = 8'h00;
                    end
                    default: begin
                    end
                endcase
                if (f_last) begin
                    state_d = ctd_pkg::S_CMD;
                end
            end
        end
        mem_rd_d = state_d == ctd_pkg::S_TX && ph_d == ctd_pkg::P_DATA;
        mem_block_d = blk_q[ti_d[7:4]];
        mem_byte_d = ti_d[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ctd_pkg::S_CMD;
            ph_q <= ctd_pkg::P_CODE;
            rq_q <= ctd_pkg::RQK_NONE;
            cmd_q <= 8'h00;
            sc_q <= 16'h0000;
            cnt_q <= 4'h0;
            left_q <= 8'h00;
            id_ok_q <= 1'b0;
            svc0_q <= 16'h0000;
            err_q <= 8'h00;
            blkn_q <= 8'h00;
            bi_q <= 4'h0;
            ti_q <= 8'h00;
            rx_ready_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_block_q <= 8'h00;
            mem_byte_q <= 4'h0;
            for (int i = 0; i < MAX_BLOCKS; i++) begin
                blk_q[i] <= 8'h00;
            end
        end else begin
            state_q <= state_d;
            ph_q <= ph_d;
            rq_q <= rq_d;
            cmd_q <= cmd_d;
            sc_q <= sc_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
            id_ok_q <= id_ok_d;
            svc0_q <= svc0_d;
            err_q <= err_d;
            blkn_q <= blkn_d;
            bi_q <= bi_d;
            ti_q <= ti_d;
            rx_ready_q <= is_rx(state_d);
            mem_rd_q <= mem_rd_d;
            mem_block_q <= mem_block_d;
            mem_byte_q <= mem_byte_d;
            blk_q <= blk_d;
        end
    end

    assign rx_ready = rx_ready_q;
    assign mem_rd = mem_rd_q;
    assign mem_block = mem_block_q;
    assign mem_byte = mem_byte_q;

    ////////////////////////////////////////////////////////////////////////////
    // response bytes queue toward the rf transmitter
    ctd_fifo #(
        .WIDTH(9),
        .DEPTH(ctd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data({f_last, f_data}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_last, tx_data})
    );
endmodule

/* ctd_fifo.sv */
// small synchronous fifo with a registered output stage
// assumes one clock shared by both sides
`timescale 1ns/1ps

module ctd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        mem_d = mem_q;
        push = in_valid && in_ready;
        pop = cnt_q != '0 && (!ov_q || out_ready);
        wr_d = wr_q;
        rd_d = rd_q;
        ov_d = ov_q && !out_ready;
        od_d = od_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
        end
        if (pop) begin
            od_d = mem_q[rd_q];
            ov_d = 1'b1;
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
        end
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
            mem_q <= mem_d;
        end
    end

    assign in_ready = cnt_q != (AW + 1)'(DEPTH);
    assign out_valid = ov_q;
    assign out_data = od_q;
endmodule

/* ctd_decoder_props.sv */
// port checker for the tag command decoder
// bound into every ctd_decoder; one clock, synchronous reset
`timescale 1ns/1ps

module ctd_decoder_chk #(
    parameter int MAX_BLOCKS = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [63:0] card_identifier,
    input wire logic [63:0] resp_time_desc,
    input wire logic [15:0] own_system_code,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic mem_rd,
    input wire logic [7:0] mem_block,
    input wire logic [3:0] mem_byte,
    input wire logic [7:0] mem_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // response byte position and captured fields
    logic [7:0] idx_q, idx_d, code_q, code_d, cnt_q, cnt_d;
    logic err_q, err_d, first_q, first_d, rd;
    assign rd = tx_valid && code_q == 8'h07;
    always_comb begin
        idx_d = idx_q;
        code_d = code_q;
        cnt_d = cnt_q;
        err_d = err_q;
        first_d = first_q;
        if (tx_valid && tx_ready) begin
            idx_d = tx_last ? 8'h00 : idx_q + 8'h01;
            if (idx_q == 8'h00) code_d = tx_data;
            if (idx_q == 8'h09) err_d = (tx_data == 8'hff);
            if (idx_q == 8'h0b) cnt_d = tx_data;
        end
        if (rx_valid && rx_ready) first_d = rx_last;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_q <= 8'h00;
            code_q <= 8'h00;
            cnt_q <= 8'h00;
            err_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            idx_q <= idx_d;
            code_q <= code_d;
            cnt_q <= cnt_d;
            err_q <= err_d;
            first_q <= first_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_release: assert property ($fell(reset) |-> (!rx_ready && !tx_valid && !mem_rd) ##1 rx_ready)
        else $error("reset exit wrong");
    a_tx_hold_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("stalled byte moved");
    a_resp_code_valid: assert property (
        tx_valid && idx_q == 8'h00 |-> tx_data inside {8'h01, 8'h07, 8'h09})
        else $error("bad response code");
    a_ident_frame_len: assert property (
        tx_valid && code_q == 8'h01 && idx_q != 8'h00 |-> (tx_last ? idx_q inside {8'h10, 8'h12} : idx_q < 8'h12))
        else $error("identify length");
    a_read_flag_one: assert property (
        rd && idx_q == 8'h09 |-> tx_data inside {8'h00, 8'hff})
        else $error("read flag 1");
    a_read_error_end: assert property (
        rd && idx_q == 8'h0a && err_q |-> tx_last && tx_data inside {8'ha1, 8'ha2, 8'ha3})
        else $error("read error end");
    a_read_count_range: assert property (
        rd && !err_q && idx_q == 8'h0b |-> tx_data inside {[8'h01:8'h0f]} && !tx_last)
        else $error("read count range");
    a_read_data_len: assert property (
        rd && !err_q && idx_q > 8'h0b |-> tx_last == (12'(idx_q) == 12'd11 + 12'(cnt_q) * 12'd16))
        else $error("read length");
    a_mem_rd_idle: assert property (mem_rd |-> !rx_ready)
        else $error("fetch while idle");
    a_unknown_silent: assert property (
        rx_valid && rx_ready && rx_last && first_q && !(rx_data inside {8'h00, 8'h06, 8'h08}) |=> rx_ready [*2])
        else $error("unknown code answered");
    c_ident: cover property (tx_valid && tx_ready && idx_q == 8'h00 && tx_data == 8'h01);
    c_read_ok: cover property (tx_valid && code_q == 8'h07 && idx_q == 8'h0b && !err_q);
    c_read_err: cover property (tx_valid && code_q == 8'h07 && idx_q == 8'h0a && err_q);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule

bind ctd_decoder ctd_decoder_chk #(.MAX_BLOCKS(MAX_BLOCKS)) u_chk (.clk, .reset, .card_identifier,
    .resp_time_desc, .own_system_code, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_data,
    .tx_last, .tx_valid, .tx_ready, .mem_rd, .mem_block, .mem_byte, .mem_rdata);

/* ctd_reader_model.sv */
// reader sink for response bytes, plus block memory
// bytes queue for the bench; stall toggles tx_ready
`timescale 1ns/1ps

module ctd_reader_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    input wire logic [7:0] mem_block,
    input wire logic [3:0] mem_byte,
    output logic [7:0] mem_rdata
);
    logic [7:0] got_q[$];
    int frames;
    // memory pattern from block and byte index
    assign mem_rdata = {mem_block[3:0], mem_byte} ^ 8'h3c;
    always @(posedge clk) begin
        if (reset) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= stall ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                got_q.push_back(tx_data);
                if (tx_last) frames++;
            end
        end
    end
endmodule

/* testbench.sv */
// self-checking bench for the tag command decoder
// drives commands; the model takes responses
`timescale 1ns/1ps

module testbench;
    localparam logic [63:0] ID = 64'h0123456789abcdef;
    localparam logic [63:0] RTD = 64'h1122334455667788;
    localparam logic [15:0] SC = 16'h12fc;
    logic clk = 1'b0;
    logic reset, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, mem_rd, stall;
    logic [7:0] rx_data, tx_data, mem_block, mem_rdata;
    logic [3:0] mem_byte;
    logic [7:0] fr[$], ex[$];
    int err_total, check_count;
    always #4 clk = ~clk;
    ctd_decoder DUT (.clk, .reset, .card_identifier(ID), .resp_time_desc(RTD),
        .own_system_code(SC), .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_data, .tx_last,
        .tx_valid, .tx_ready, .mem_rd, .mem_block, .mem_byte, .mem_rdata);
    ctd_reader_model PART (.clk, .reset, .stall, .tx_valid, .tx_data, .tx_last, .tx_ready,
        .mem_block, .mem_byte, .mem_rdata);
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            err_total++;
        end
    endtask
    task timed_out(input string name);
        $display("ERROR %s expected done seen timeout", name);
        err_total++;
        report_and_stop();
    endtask
    function automatic void p64(ref logic [7:0] q[$], input logic [63:0] v);
        for (int i = 7; i >= 0; i--) q.push_back(v[i*8 +: 8]);
    endfunction
    // frame bytes held until taken
    task send;
        int n;
        for (int i = 0; i < fr.size(); i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = fr[i];
            rx_last = (i == fr.size() - 1);
            n = 0;
            while (rx_ready !== 1'b1) begin
                @(negedge clk);
                n++;
                if (n > 4000) timed_out("rx_ready");
            end
            @(posedge clk);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_last = 1'b0;
    endtask
    task expect_rsp;
        int n;
        n = 0;
        while (PART.frames == 0) begin
            @(negedge clk);
            n++;
            if (n > 4000) timed_out("response");
        end
        chk("rsp_len", 8'(ex.size()), 8'(PART.got_q.size()));
        for (int i = 0; i < ex.size() && i < PART.got_q.size(); i++) chk("rsp_byte", ex[i], PART.got_q[i]);
        PART.got_q.delete();
        PART.frames = 0;
    endtask
    task expect_none;
        repeat (80) @(negedge clk);
        chk("silent_len", 8'h00, 8'(PART.got_q.size()));
        PART.got_q.delete();
        PART.frames = 0;
    endtask
    task mk_read(input logic [7:0] code, kn, input bit df, input logic [7:0] mn, input logic [63:0] id);
        fr = {code};
        p64(fr, id);
        fr.push_back(kn);
        for (int k = 0; k < kn; k++) fr = {fr, 8'h09, (df && k == kn - 1) ? 8'h01 : 8'h00};
        fr.push_back(mn);
        for (int b = 0; b < mn; b++) fr = {fr, 8'h80, 8'(b)};
    endtask
    ////////////////////////////////////////////////////////////////
    task t_ident;
        logic [15:0] sc[4] = '{16'hffff, 16'haaff, SC, 16'h1234};
        logic [7:0] rq[4] = '{8'h00, 8'h01, 8'h02, 8'h7e};
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 4; r++) begin
                fr = {8'h00, sc[s][15:8], sc[s][7:0], rq[r], 8'(s + r)};
                send();
                if (s == 3) begin
                    expect_none();
                end else begin
                    ex = {8'h01};
                    p64(ex, ID);
                    p64(ex, RTD);
                    if (rq[r] == 8'h01) ex = {ex, SC[15:8], SC[7:0]};
                    if (rq[r] == 8'h02) ex = {ex, 8'h00, 8'h83};
                    expect_rsp();
                end
            end
        end
        $display("identify test done");
    endtask
    task t_read_ok;
        logic [7:0] n[2] = '{8'h01, 8'h0f};
        for (int t = 0; t < 2; t++) begin
            stall = (t == 1);
            mk_read(8'h06, n[t], 1'b0, n[t], ID);
            send();
            ex = {8'h07};
            p64(ex, ID);
            ex = {ex, 8'h00, 8'h00, n[t]};
            for (int b = 0; b < n[t]; b++)
                for (int j = 0; j < 16; j++) ex.push_back({4'(b), 4'(j)} ^ 8'h3c);
            expect_rsp();
        end
        stall = 1'b0;
        $display("read test done");
    endtask
    task t_read_err;
        logic [7:0] kn[5] = '{8'h00, 8'h10, 8'h02, 8'h01, 8'h01};
        bit df[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [7:0] mn[5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h10};
        logic [7:0] s2[5] = '{8'ha1, 8'ha1, 8'ha3, 8'ha2, 8'ha2};
        for (int t = 0; t < 5; t++) begin
            mk_read(8'h06, kn[t], df[t], mn[t], ID);
            send();
            ex = {8'h07};
            p64(ex, ID);
            ex = {ex, 8'hff, s2[t]};
            expect_rsp();
        end
        $display("read error test done");
    endtask
    task t_write_and_silent;
        logic [7:0] cd[4] = '{8'h01, 8'h05, 8'h07, 8'hff};
        mk_read(8'h08, 8'h01, 1'b0, 8'h01, ID);
        for (int i = 0; i < 16; i++) fr.push_back(8'(i));
        send();
        ex = {8'h09};
        p64(ex, ID);
        ex = {ex, 8'h00, 8'h00};
        expect_rsp();
        mk_read(8'h06, 8'h01, 1'b0, 8'h01, ~ID);
        send();
        expect_none();
        for (int i = 0; i < 4; i++) begin
            fr = {cd[i]};
            send();
            expect_none();
        end
        $display("write and silence test done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        stall = 1'b0;
        err_total = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_ident();
        t_read_ok();
        t_read_err();
        t_write_and_silent();
        report_and_stop();
    end
endmodule
